// ### rtl/tli_irq_top.sv
// top of the two-level interrupt logic
// assumes block events are one-cycle or level inputs on i_clk,
// gpio pins are asynchronous, software access is by plain ports
`timescale 1ns/1ps
`default_nettype none
module tli_irq_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // block event sources, one bank per block
    input wire logic [tli_pkg::TLI_NUM_BLK*tli_pkg::TLI_SEC_W-1:0] i_blk_evt,
    // software clear and mask, one word per block
    input wire logic [tli_pkg::TLI_NUM_BLK*tli_pkg::TLI_SEC_W-1:0] i_blk_clr,
    input wire logic [tli_pkg::TLI_NUM_BLK*tli_pkg::TLI_SEC_W-1:0] i_blk_mask,
    // gpio pins and their setup
    input wire logic [tli_pkg::TLI_NUM_GPIO-1:0] i_gpio,
    input wire logic [tli_pkg::TLI_NUM_GPIO-1:0] i_gpio_is_in,
    input wire logic [tli_pkg::TLI_NUM_GPIO-1:0] i_gpio_act_hi,
    input wire logic [tli_pkg::TLI_NUM_GPIO-1:0] i_gpio_clr,
    input wire logic [tli_pkg::TLI_NUM_GPIO-1:0] i_gpio_mask,
    // status seen by software
    output logic [tli_pkg::TLI_NUM_BLK*tli_pkg::TLI_SEC_W-1:0] o_blk_flags,
    output logic [tli_pkg::TLI_NUM_GPIO-1:0] o_gpio_flags,
    output logic [tli_pkg::TLI_PRI_W-1:0] o_primary,
    // request pin to the host
    output logic o_irq
);
    import tli_pkg::*;

    // ==========================================================
    // gpio synchroniser: first stage read only by second
    logic [TLI_NUM_GPIO-1:0] gpio_s1_r;
    logic [TLI_NUM_GPIO-1:0] gpio_s2_r;
    logic [TLI_NUM_GPIO-1:0] gpio_act_r;
    logic [TLI_NUM_GPIO-1:0] gpio_evt;

    // no reset: stages follow the pins during reset, so a pin
    // already asserted at release is not taken for an edge
    always_ff @(posedge i_clk) begin
        gpio_s1_r <= i_gpio;
        gpio_s2_r <= gpio_s1_r;
    end

    // ==========================================================
    // polarity and edge detect on the asserted level
    function automatic logic [TLI_NUM_GPIO-1:0] asserted(
        input logic [TLI_NUM_GPIO-1:0] lvl,
        input logic [TLI_NUM_GPIO-1:0] hi);
        asserted = ~(lvl ^ hi);
    endfunction : asserted

    // act_r resets to asserted-looking so a pin idling active
    // does not fire at reset release
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            gpio_act_r <= '1;
        end else begin
            gpio_act_r <= asserted(gpio_s2_r, i_gpio_act_hi);
        end
    end

    // edge trigger: the bit latches, so a held level adds nothing
    assign gpio_evt = asserted(gpio_s2_r, i_gpio_act_hi) & ~gpio_act_r
                      & i_gpio_is_in;

    // ==========================================================
    // banks
    logic [TLI_PRI_W-1:0] prim;

    tli_sec_if #(.W(TLI_SEC_W)) blk_if [TLI_NUM_BLK] ();
    tli_sec_if #(.W(TLI_NUM_GPIO)) gp_if ();

    for (genvar b = 0; b < TLI_NUM_BLK; b++) begin : g_blk
        assign blk_if[b].evt = i_blk_evt[b*TLI_SEC_W +: TLI_SEC_W];
        assign blk_if[b].clr = i_blk_clr[b*TLI_SEC_W +: TLI_SEC_W];
        assign blk_if[b].mask = i_blk_mask[b*TLI_SEC_W +: TLI_SEC_W];
        assign o_blk_flags[b*TLI_SEC_W +: TLI_SEC_W] = blk_if[b].flags;
        assign prim[b] = blk_if[b].prim;
        tli_sec_bank #(.W(TLI_SEC_W)) u_bank (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .bus(blk_if[b])
        );
    end

    assign gp_if.evt = gpio_evt;
    assign gp_if.clr = i_gpio_clr;
    assign gp_if.mask = i_gpio_mask;
    assign o_gpio_flags = gp_if.flags;
    assign prim[TLI_GPIO_PRI] = gp_if.prim;

    tli_sec_bank #(.W(TLI_NUM_GPIO)) u_gpio_bank (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .bus(gp_if)
    );

    // ==========================================================
    // registered request pin, one cycle after primary
    logic irq_r;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |prim;
        end
    end

    assign o_primary = prim;
    assign o_irq = irq_r;

    // ==========================================================
    // checks on the request pin
    // pin is registered, hence one cycle behind the primaries
    AST_IRQ_FOLLOWS: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        |prim |=> o_irq)
        else $error("request pin missed active primary");
    AST_IRQ_DROPS: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !(|prim) |=> !o_irq)
        else $error("request pin stuck with no primary");
    AST_IRQ_SOURCE: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_irq |-> $past(|prim))
        else $error("request pin raised with no primary");
    // first cycle after any reset: nothing pending, no stray edge
    AST_RST_QUIET: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> !o_irq && (o_blk_flags == '0)
        && (o_gpio_flags == '0) && (gpio_evt == '0))
        else $error("state not quiet after reset");

    // ==========================================================
    // checks on the gpio triggers
    AST_GPIO_EDGE: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_gpio_is_in[0] && i_gpio_act_hi[0] && !gpio_s2_r[0]
        ##1 gpio_s2_r[0] && i_gpio_is_in[0] && i_gpio_act_hi[0]
        |=> o_gpio_flags[0])
        else $error("gpio edge did not set its bit");
    AST_GPIO_LOW: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_gpio_is_in[1] && !i_gpio_act_hi[1] && gpio_s2_r[1]
        ##1 !gpio_s2_r[1] && i_gpio_is_in[1] && !i_gpio_act_hi[1]
        |=> o_gpio_flags[1])
        else $error("active-low gpio did not set its bit");
    AST_OUT_DIR: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_gpio_is_in[2] |-> !gpio_evt[2])
        else $error("output gpio raised an event");

    // every pin; the past reset term skips the cycle where the
    // edge detector still holds its reset value
    for (genvar g = 0; g < TLI_NUM_GPIO; g++) begin : g_pin_chk
        AST_PIN_EDGE: assert property (
            @(posedge i_clk) disable iff (!i_rst_n)
            $past(i_rst_n) && i_gpio_is_in[g]
            && $stable(i_gpio_act_hi[g]) && $changed(gpio_s2_r[g])
            && (gpio_s2_r[g] == i_gpio_act_hi[g])
            |=> o_gpio_flags[g])
            else $error("gpio pin edge did not set its bit");
        AST_NO_RETRIG: assert property (
            @(posedge i_clk) disable iff (!i_rst_n)
            gpio_evt[g] ##1 $stable(i_gpio_act_hi[g]) |-> !gpio_evt[g])
            else $error("held gpio level fired twice");
    end

    // ==========================================================
    // checks on the latched words
    AST_READ_KEEP: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_blk_flags[0] && !i_blk_clr[0] |=> o_blk_flags[0])
        else $error("bit lost without clear");
    AST_BLK_SET: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_blk_evt != '0) |=>
        ((o_blk_flags & $past(i_blk_evt)) == $past(i_blk_evt)))
        else $error("block event not recorded");
    // set wins over a clear in the same cycle
    AST_BLK_CLR: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        ((i_blk_clr & ~i_blk_evt) != '0) |=>
        ((o_blk_flags & $past(i_blk_clr & ~i_blk_evt)) == '0))
        else $error("block bit not cleared by a one");
    AST_BLK_KEEP: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |=> ((o_blk_flags & $past(o_blk_flags & ~i_blk_clr))
        == $past(o_blk_flags & ~i_blk_clr)))
        else $error("block bit dropped without a one");
    AST_GPIO_KEEP: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |=> ((o_gpio_flags & $past(o_gpio_flags & ~i_gpio_clr))
        == $past(o_gpio_flags & ~i_gpio_clr)))
        else $error("gpio bit dropped without a one");

    // ==========================================================
    // scenarios worth seeing
    COV_IRQ_CYCLE: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        !o_irq ##1 o_irq ##[1:20] !o_irq);
    COV_GPIO_IRQ: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        gpio_evt[0] ##[1:3] o_irq);
    COV_MASKED: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        o_gpio_flags[3] && i_gpio_mask[3] && !o_irq);
    COV_HOST_CLEAR: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        o_irq ##1 (i_blk_clr != '0) ##[1:3] !o_irq);
endmodule : tli_irq_top
`default_nettype wire

// ### rtl/tli_pkg.sv
// package for the two-level interrupt logic
// assumes one system clock and synchronous active-low reset
package tli_pkg;
    // ==========================================================
    // sizes
    localparam int TLI_NUM_GPIO = 12;
    localparam int TLI_NUM_BLK = 4;
    localparam int TLI_SEC_W = 16;
    localparam int TLI_PRI_W = TLI_NUM_BLK + 1;
    localparam int TLI_GPIO_PRI = TLI_NUM_BLK;
    // ==========================================================
    // reset values
    localparam logic [TLI_SEC_W-1:0] TLI_MASK_RST = 16'hffff;
    localparam logic [TLI_NUM_GPIO-1:0] TLI_GMASK_RST = 12'hfff;
    localparam logic [TLI_NUM_GPIO-1:0] TLI_POL_RST = 12'hfff;
    localparam logic [TLI_NUM_GPIO-1:0] TLI_DIR_RST = 12'hfff;
    // ==========================================================
    // gpio trigger modes
    typedef enum logic [1:0] {
        TLI_TRIG_IDLE = 2'b00,
        TLI_TRIG_ARMED = 2'b01,
        TLI_TRIG_FIRED = 2'b10
    } tli_trig_t;
endpackage : tli_pkg

// ### rtl/tli_sec_if.sv
// interface carrying one group of secondary interrupt bits
// assumes the caller and the bank share i_clk
`timescale 1ns/1ps
`default_nettype none
interface tli_sec_if #(parameter int W = 16);
    logic [W-1:0] evt;
    logic [W-1:0] clr;
    logic [W-1:0] mask;
    logic [W-1:0] flags;
    logic prim;
    modport ctrl (output evt, output clr, output mask,
                  input flags, input prim);
    modport bank (input evt, input clr, input mask,
                  output flags, output prim);
endinterface : tli_sec_if
`default_nettype wire

// ### rtl/tli_sec_bank.sv
// latching secondary bank with masked or into one primary
// assumes events and clears are synchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
module tli_sec_bank #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // bank side
    tli_sec_if.bank bus
);
    import tli_pkg::*;

    logic [W-1:0] flags_r;
    logic [W-1:0] flags_nxt;

    // ==========================================================
    // latch: set beats clear so no event is lost
    always_comb begin
        flags_nxt = (flags_r & ~bus.clr) | bus.evt;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign bus.flags = flags_r;
    assign bus.prim = |(flags_r & ~bus.mask);

    // ==========================================================
    // checks
    AST_LATCH_HOLD: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        flags_r[0] && !bus.clr[0] |=> flags_r[0])
        else $error("secondary bit dropped without clear");
    AST_CLEAR: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        bus.clr[0] && !bus.evt[0] |=> !flags_r[0])
        else $error("write one did not clear bit");
    AST_SET: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        bus.evt[0] |=> flags_r[0])
        else $error("event not recorded");
    AST_PRIM_OR: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        bus.evt[0] ##1 !bus.mask[0] |-> bus.prim)
        else $error("primary not raised by unmasked bit");
    AST_MASKED: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (&bus.mask) |-> !bus.prim)
        else $error("masked bits reach primary");
    COV_SET_CLR: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        bus.evt[0] ##1 flags_r[0] ##[1:4] bus.clr[0] ##1 !flags_r[0]);
endmodule : tli_sec_bank
`default_nettype wire

// ### dv/tli_host_model.sv
// host model serving the request pin of the interrupt logic
// assumes it shares i_clk with the block under test
`timescale 1ns/1ps
`default_nettype none
module tli_host_model #(
    parameter int BW = 64,
    parameter int GW = 12
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // service enable and request pin
    input wire logic i_en,
    input wire logic i_irq,
    // flags read by the host
    input wire logic [BW-1:0] i_blk_flags,
    input wire logic [GW-1:0] i_gpio_flags,
    // write-one-to-clear strobes
    output logic [BW-1:0] o_blk_clr,
    output logic [GW-1:0] o_gpio_clr
);
    // ==========================================================
    // service: read the flags, write back ones for what was seen
    // writes only bits it read as set, so newer events survive
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !i_en || !i_irq) begin
            o_blk_clr <= '0;
            o_gpio_clr <= '0;
        end else begin
            o_blk_clr <= i_blk_flags;
            o_gpio_clr <= i_gpio_flags;
        end
    end
endmodule : tli_host_model
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the two-level interrupt logic
// assumes the host model and design share one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tli_pkg::*;
    localparam int BW = TLI_NUM_BLK * TLI_SEC_W;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [BW-1:0] evt = '0, tclr = '0, mask = '0, hclr, flags;
    logic [TLI_NUM_GPIO-1:0] gpio = '0, isin = 12'hffb, hi = 12'hffd;
    logic [TLI_NUM_GPIO-1:0] tgclr = '0, hgclr, gflags, gmask = '0;
    logic [TLI_PRI_W-1:0] prim;
    logic irq;
    logic hen = 1'b0;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    tli_irq_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_blk_evt(evt), .i_blk_clr(tclr | hclr), .i_blk_mask(mask),
        .i_gpio(gpio), .i_gpio_is_in(isin), .i_gpio_act_hi(hi),
        .i_gpio_clr(tgclr | hgclr), .i_gpio_mask(gmask),
        .o_blk_flags(flags), .o_gpio_flags(gflags),
        .o_primary(prim), .o_irq(irq));
    tli_host_model #(.BW(BW), .GW(TLI_NUM_GPIO)) u_host (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_en(hen), .i_irq(irq),
        .i_blk_flags(flags), .i_gpio_flags(gflags),
        .o_blk_clr(hclr), .o_gpio_clr(hgclr));
    // ==========================================================
    // clock, timeout and helpers
    initial forever #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            results();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [BW-1:0] e, g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    // ==========================================================
    // scenarios
    task automatic t_event();
        evt[17] = 1'b1;
        tick(1);
        evt = '0;
        chk("flags", 64'h20000, flags);
        chk("prim", 5'h02, prim);
        tick(1);
        chk("irq", 1'b1, irq);
        tick(3);
        chk("flags held", 64'h20000, flags);
        mask[17] = 1'b1;
        #1;
        chk("prim masked", 5'h00, prim);
        tick(1);
        chk("irq masked", 1'b0, irq);
        mask = '0;
        tick(1);
        chk("irq unmasked", 1'b1, irq);
    endtask : t_event
    task automatic t_clear();
        tclr = 64'h1;
        tick(1);
        tclr = '0;
        chk("flags w0", 64'h20000, flags);
        tclr[17] = 1'b1;
        tick(1);
        tclr = '0;
        chk("flags w1", 64'h0, flags);
        tick(1);
        chk("irq clr", 1'b0, irq);
    endtask : t_clear
    task automatic t_gpio();
        gpio = 12'h005;
        tick(3);
        chk("gflags hi", 12'h001, gflags);
        chk("prim gpio", 5'h10, prim);
        gpio[1] = 1'b1;
        tick(3);
        chk("gflags lo idle", 12'h001, gflags);
        gpio[1] = 1'b0;
        tick(3);
        chk("gflags lo", 12'h003, gflags);
        tgclr = 12'h003;
        tick(1);
        tgclr = '0;
        chk("gflags clr", 12'h000, gflags);
    endtask : t_gpio
    task automatic t_host();
        hen = 1'b1;
        evt[0] = 1'b1;
        tick(1);
        evt = '0;
        tick(6);
        chk("host flags", 64'h0, flags);
        chk("host irq", 1'b0, irq);
        hen = 1'b0;
    endtask : t_host
    task automatic t_gmask();
        gmask = 12'h008;
        gpio[3] = 1'b1;
        tick(3);
        chk("gflags masked", 12'h008, gflags);
        chk("prim gmask", 5'h00, prim);
        tick(1);
        chk("irq gmask", 1'b0, irq);
        gmask = '0;
        #1;
        chk("prim gunmask", 5'h10, prim);
        tick(1);
        chk("irq gunmask", 1'b1, irq);
        tgclr = 12'h008;
        tick(1);
        tgclr = '0;
        chk("gflags clr3", 12'h000, gflags);
    endtask : t_gmask
    task automatic t_reset();
        evt[40] = 1'b1;
        tick(1);
        evt = '0;
        chk("flags pre rst", 64'h100_0000_0000, flags);
        i_rst_n = 1'b0;
        tick(2);
        chk("rst flags mid", 64'h0, flags);
        i_rst_n = 1'b1;
        tick(4);
        chk("rst gflags mid", 12'h000, gflags);
        chk("rst irq mid", 1'b0, irq);
    endtask : t_reset
    // ==========================================================
    // main sequence
    initial begin
        tick(8);
        chk("rst flags", 64'h0, flags);
        chk("rst irq", 1'b0, irq);
        i_rst_n = 1'b1;
        tick(2);
        t_event();
        t_clear();
        t_gpio();
        t_gmask();
        t_reset();
        t_host();
        results();
    end
endmodule : testbench
`default_nettype wire
